/* core/key_port_map.vh */
`ifndef KEY_PORT_MAP_VH
`define KEY_PORT_MAP_VH
// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define KEY_SCAN_WIDTH 8
`define KEY_SCAN_RST_DATA 8'hFF
`define KEY_SCAN_RST_DIR 1'h1
`define SENSE_A_RST_IN_EN 1'h0
`define SENSE_B_RST_LED 1'h1
`define SENSE_PULL_RST 1'h0
// ----------------------------------------
// Carrier select codes
// ----------------------------------------
`define CAR_SEL_W 3
`define CAR_FX 3'h0
`define CAR_FX8 3'h1
`define CAR_FX12 3'h2
`define CAR_HIGH 3'h3
`define CAR_FX2 3'h4
`define CAR_FX16 3'h5
`define CAR_FX24 3'h6
`define CAR_DIV_W 5
// ----------------------------------------
// Carrier half periods in clock cycles
// ----------------------------------------
`define CAR_HALF_FX2 5'h01
`define CAR_HALF_FX8 5'h04
`define CAR_HALF_FX12 5'h06
`define CAR_HALF_FX16 5'h08
`define CAR_HALF_FX24 5'h0C
`define CAR_HALF_NONE 5'h00
`endif

/* core/key_matrix_port_pins.v */
`timescale 1ns/1ps
`default_nettype none
`include "key_port_map.vh"
module key_matrix_port_pins #(
    parameter WIDTH = `KEY_SCAN_WIDTH
) (
    input wire CLOCK,
    input wire ARST_N,
    input wire [WIDTH-1:0] KEY_SCAN_DATA,
    input wire KEY_SCAN_OUT_MODE,
    input wire SENSE_A_IN_EN,
    input wire SENSE_B_LED_MODE,
    input wire SENSE_PULL_EN,
    input wire CARRIER_EN,
    input wire [`CAR_SEL_W-1:0] CARRIER_SEL,
    input wire [WIDTH-1:0] KEY_SCAN_LINES_IN,
    output wire [WIDTH-1:0] KEY_SCAN_LINES_OUT,
    output wire [WIDTH-1:0] KEY_SCAN_LINES_OE,
    output wire [WIDTH-1:0] KEY_SCAN_LINES_PD,
    input wire SENSE_A_IN,
    output wire SENSE_A_PD,
    input wire SENSE_B_INDICATOR_IN,
    output wire SENSE_B_INDICATOR_OUT,
    output wire SENSE_B_INDICATOR_OE,
    output wire SENSE_B_PD,
    output reg IR_TRANSMIT_OUT,
    output reg [WIDTH-1:0] KEY_SCAN_READ,
    output reg SENSE_A_READ,
    output reg SENSE_B_READ
);
// ----------------------------------------
// Port settings
// ----------------------------------------
reg [WIDTH-1:0] scan_data_ff;
reg scan_out_ff;
reg sense_a_in_ff;
reg sense_b_led_ff;
reg sense_pull_ff;
always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        scan_data_ff <= {WIDTH{1'b1}};
        scan_out_ff <= `KEY_SCAN_RST_DIR;
        sense_a_in_ff <= `SENSE_A_RST_IN_EN;
        sense_b_led_ff <= `SENSE_B_RST_LED;
        sense_pull_ff <= `SENSE_PULL_RST;
    end else begin
        scan_data_ff <= KEY_SCAN_DATA;
        scan_out_ff <= KEY_SCAN_OUT_MODE;
        sense_a_in_ff <= SENSE_A_IN_EN;
        sense_b_led_ff <= SENSE_B_LED_MODE;
        sense_pull_ff <= SENSE_PULL_EN;
    end
end
// ----------------------------------------
// Key scan lines
// ----------------------------------------
assign KEY_SCAN_LINES_OUT = scan_data_ff;
assign KEY_SCAN_LINES_OE = {WIDTH{scan_out_ff}};
assign KEY_SCAN_LINES_PD = {WIDTH{~scan_out_ff}};
// ----------------------------------------
// Sense pins
// ----------------------------------------
reg sense_a_pd_ff;
reg sense_b_pd_ff;
always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        sense_a_pd_ff <= `SENSE_PULL_RST;
        sense_b_pd_ff <= `SENSE_PULL_RST;
    end else begin
        sense_a_pd_ff <= SENSE_A_IN_EN & SENSE_PULL_EN;
        sense_b_pd_ff <= ~SENSE_B_LED_MODE & SENSE_PULL_EN;
    end
end
assign SENSE_A_PD = sense_a_pd_ff;
assign SENSE_B_PD = sense_b_pd_ff;
assign SENSE_B_INDICATOR_OE = sense_b_led_ff;
// ----------------------------------------
// Pin read gating
// ----------------------------------------
function pin_read;
    input in_mode;
    input level;
    begin
        pin_read = in_mode & level;
    end
endfunction
// ----------------------------------------
// Key scan synchronisers
// ----------------------------------------
wire [WIDTH-1:0] scan_sync;
genvar g;
generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_scan_sync
        reg s1_ff;
        reg s2_ff;
        always @(posedge CLOCK or negedge ARST_N) begin
            if (!ARST_N) begin
                s1_ff <= 1'b0;
                s2_ff <= 1'b0;
            end else begin
                s1_ff <= KEY_SCAN_LINES_IN[g];
                s2_ff <= s1_ff;
            end
        end
        assign scan_sync[g] = s2_ff;
    end
endgenerate
// ----------------------------------------
// Sense synchronisers and read data
// ----------------------------------------
reg sa_s1_ff;
reg sa_s2_ff;
reg sb_s1_ff;
reg sb_s2_ff;
always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        sa_s1_ff <= 1'h0;
        sa_s2_ff <= 1'h0;
        sb_s1_ff <= 1'h0;
        sb_s2_ff <= 1'h0;
        KEY_SCAN_READ <= {WIDTH{1'b0}};
        SENSE_A_READ <= 1'h0;
        SENSE_B_READ <= 1'h0;
    end else begin
        sa_s1_ff <= SENSE_A_IN;
        sa_s2_ff <= sa_s1_ff;
        sb_s1_ff <= SENSE_B_INDICATOR_IN;
        sb_s2_ff <= sb_s1_ff;
        KEY_SCAN_READ <= scan_out_ff ? {WIDTH{1'b0}} : scan_sync;
        SENSE_A_READ <= pin_read(sense_a_in_ff, sa_s2_ff);
        SENSE_B_READ <= pin_read(~sense_b_led_ff, sb_s2_ff);
    end
end
// ----------------------------------------
// Carrier generation
// ----------------------------------------
function [`CAR_DIV_W-1:0] half_period;
    input [`CAR_SEL_W-1:0] sel;
    begin
        case (sel)
            `CAR_FX2: half_period = `CAR_HALF_FX2;
            `CAR_FX8: half_period = `CAR_HALF_FX8;
            `CAR_FX12: half_period = `CAR_HALF_FX12;
            `CAR_FX16: half_period = `CAR_HALF_FX16;
            `CAR_FX24: half_period = `CAR_HALF_FX24;
            default: half_period = `CAR_HALF_NONE;
        endcase
    end
endfunction
reg [`CAR_DIV_W-1:0] div_cnt_ff;
reg car_ph_ff;
wire [`CAR_DIV_W-1:0] div_half;
assign div_half = half_period(CARRIER_SEL);
always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        div_cnt_ff <= 5'h00;
        car_ph_ff <= 1'h0;
    end else if (!CARRIER_EN) begin
        div_cnt_ff <= 5'h00;
        car_ph_ff <= 1'h0;
    end else if (div_cnt_ff + 5'h01 >= div_half) begin
        div_cnt_ff <= 5'h00;
        car_ph_ff <= ~car_ph_ff;
    end else begin
        div_cnt_ff <= div_cnt_ff + 5'h01;
    end
end
// ----------------------------------------
// Clock-rate carrier phase
// ----------------------------------------
reg fx_ph_ff;
always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        fx_ph_ff <= 1'h0;
    end else begin
        fx_ph_ff <= ~fx_ph_ff;
    end
end
// ----------------------------------------
// Carrier select
// ----------------------------------------
reg nxt_ir;
always @* begin
    nxt_ir = 1'b0;
    if (CARRIER_EN) begin
        case (CARRIER_SEL)
            `CAR_HIGH: nxt_ir = 1'b1;
            `CAR_FX: nxt_ir = ~fx_ph_ff;
            default: nxt_ir = ~car_ph_ff;
        endcase
    end
end
// ----------------------------------------
// Output registers
// ----------------------------------------
reg led_out_ff;
always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
        IR_TRANSMIT_OUT <= 1'h0;
        led_out_ff <= `SENSE_B_RST_LED;
    end else begin
        IR_TRANSMIT_OUT <= nxt_ir;
        led_out_ff <= ~nxt_ir;
    end
end
assign SENSE_B_INDICATOR_OUT = led_out_ff;
endmodule // key_matrix_port_pins
`default_nettype wire

/* tb/key_matrix_port_pins_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module key_matrix_port_pins_checker (
    input wire CLOCK, ARST_N, KEY_SCAN_OUT_MODE, SENSE_A_IN_EN, SENSE_B_LED_MODE,
    input wire SENSE_PULL_EN, CARRIER_EN, SENSE_A_PD, SENSE_B_INDICATOR_OUT,
    input wire SENSE_B_INDICATOR_OE, IR_TRANSMIT_OUT, SENSE_A_READ, SENSE_B_PD,
    input wire [7:0] KEY_SCAN_DATA, KEY_SCAN_LINES_OUT, KEY_SCAN_LINES_OE, KEY_SCAN_LINES_PD
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    dir_all_a: assert property ($past(ARST_N) |->
        KEY_SCAN_LINES_OE == {8{$past(KEY_SCAN_OUT_MODE)}}) else $error("dir");
    scan_pull_a: assert property (KEY_SCAN_LINES_PD == ~KEY_SCAN_LINES_OE)
        else $error("pull");
    scan_drive_a: assert property ($past(ARST_N) && $past(KEY_SCAN_OUT_MODE) |->
        KEY_SCAN_LINES_OUT == $past(KEY_SCAN_DATA)) else $error("drive");
    sense_pull_a: assert property ($past(ARST_N) |->
        SENSE_A_PD == ($past(SENSE_A_IN_EN) && $past(SENSE_PULL_EN))) else $error("a pull");
    sense_b_pull_a: assert property ($past(ARST_N) |->
        SENSE_B_PD == (!$past(SENSE_B_LED_MODE) && $past(SENSE_PULL_EN))) else $error("b pull");
    led_mode_a: assert property ($past(ARST_N) |->
        SENSE_B_INDICATOR_OE == $past(SENSE_B_LED_MODE)) else $error("led mode");
    led_follow_a: assert property (SENSE_B_INDICATOR_OUT != IR_TRANSMIT_OUT)
        else $error("led");
    idle_low_a: assert property (!CARRIER_EN [*2] |=> !IR_TRANSMIT_OUT)
        else $error("idle");
    off_read_a: assert property (!SENSE_A_IN_EN [*3] |=> !SENSE_A_READ)
        else $error("off read");
    cover property (CARRIER_EN && IR_TRANSMIT_OUT);
    cover property (SENSE_A_READ);
    cover property (!KEY_SCAN_OUT_MODE ##1 KEY_SCAN_OUT_MODE);
endmodule // key_matrix_port_pins_checker
`default_nettype wire

/* tb/key_matrix_model.sv */
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model (
    input wire logic CLOCK, SENSE_A_PD,
    input wire logic [3:0] key_a,
    input wire logic [7:0] KEY_SCAN_LINES_OUT, KEY_SCAN_LINES_OE,
    output logic [7:0] KEY_SCAN_LINES_IN,
    output logic SENSE_A_IN
);
    logic flip = 1'b0;
    always @(posedge CLOCK) flip <= ~flip;
    // Open return line wanders unless pulled down
    assign KEY_SCAN_LINES_IN = KEY_SCAN_LINES_OE & KEY_SCAN_LINES_OUT;
    assign SENSE_A_IN = key_a[3] ? KEY_SCAN_LINES_IN[key_a[2:0]] : !SENSE_A_PD && flip;
endmodule // key_matrix_model
`default_nettype wire

/* tb/test_key_matrix_port_pins.sv */
`timescale 1ns/1ps
`default_nettype none
module test_key_matrix_port_pins;
    logic CLOCK = 1'b0, ARST_N = 1'b0, KEY_SCAN_OUT_MODE = 1'b1, SENSE_A_IN_EN = 1'b0;
    logic SENSE_B_LED_MODE = 1'b1, SENSE_PULL_EN = 1'b0, CARRIER_EN = 1'b0, ir_l = 1'b0;
    logic SENSE_A_IN, SENSE_A_PD, SENSE_B_INDICATOR_OUT, SENSE_B_INDICATOR_OE, SENSE_B_PD;
    logic SENSE_B_INDICATOR_IN, IR_TRANSMIT_OUT, SENSE_A_READ, SENSE_B_READ, clr_rises = 1'b0;
    logic [2:0] CARRIER_SEL = 3'h0, key_b = 3'h0;
    logic [3:0] key_a = 4'h0;
    logic [7:0] KEY_SCAN_DATA = 8'hFF, KEY_SCAN_LINES_IN, KEY_SCAN_LINES_OUT, KEY_SCAN_READ;
    logic [7:0] KEY_SCAN_LINES_OE, KEY_SCAN_LINES_PD, d, rises = 8'h0;
    logic [7:0] ups [8] = '{8'h18, 8'h6, 8'h4, 8'h0, 8'h18, 8'h3, 8'h2, 8'h18};
    logic [63:0] n, q[$];
    logic [31:0] seen;
    integer fail_count = 0, checks = 0, seed = 32'h2347, i;
    key_matrix_port_pins i_dut (.*);
    key_matrix_model i_keys (.*);
    assign SENSE_B_INDICATOR_IN = SENSE_B_INDICATOR_OE ? SENSE_B_INDICATOR_OUT
        : KEY_SCAN_LINES_IN[key_b];
    assign seen = {rises, KEY_SCAN_LINES_OUT, KEY_SCAN_READ, SENSE_A_READ, SENSE_B_READ,
        IR_TRANSMIT_OUT, SENSE_A_PD, SENSE_B_INDICATOR_OE, SENSE_B_INDICATOR_OUT,
        KEY_SCAN_LINES_OE[0], KEY_SCAN_LINES_PD[0]};
    always #50 CLOCK = ~CLOCK;
    task note_it(input logic [31:0] m, input logic [31:0] e);
        repeat (4) @(negedge CLOCK);
        q.push_back({m, e});
        @(negedge CLOCK);
    endtask
    always @(posedge CLOCK) begin
        #1;
        if (q.size() > 0) begin
            n = q.pop_front();
            checks++;
            if ((seen & n[63:32]) !== n[31:0]) begin
                fail_count++;
                $display("BAD status expected %h seen %h", n[31:0], seen & n[63:32]);
            end
        end
        if (clr_rises) rises = 8'h0;
        else if (IR_TRANSMIT_OUT && !ir_l) rises++;
        ir_l = IR_TRANSMIT_OUT;
    end
    initial begin
        note_it(32'h3F, 32'hE);
        repeat (1) @(negedge CLOCK);
        ARST_N = 1'b1;
        $display("reset test done");
        {SENSE_A_IN_EN, SENSE_B_LED_MODE} = 2'h2;
        SENSE_PULL_EN = 1'($random(seed));
        note_it(32'h3F, {SENSE_PULL_EN, 4'h6});
        for (i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            KEY_SCAN_DATA = d;
            key_a = {1'b1, i[2:0]};
            key_b = ~i[2:0];
            note_it(32'hFF00C0, {8'h0, d, 8'h0, d[i], d[key_b], 6'h0});
        end
        KEY_SCAN_DATA = 8'hFF;
        SENSE_A_IN_EN = 1'b0;
        note_it(32'hC0, 32'h40);
        KEY_SCAN_OUT_MODE = 1'b0;
        note_it(32'hFF00, 32'h0);
        $display("scan test done");
        {KEY_SCAN_OUT_MODE, SENSE_B_LED_MODE, SENSE_PULL_EN, CARRIER_EN} = 4'hD;
        for (i = 0; i < 8; i++) begin
            CARRIER_SEL = i[2:0];
            repeat (8) @(negedge CLOCK);
            clr_rises = 1'b1;
            @(negedge CLOCK);
            clr_rises = 1'b0;
            repeat (44) @(negedge CLOCK);
            note_it(32'hFF000000, {ups[i], 24'h0});
            if (i == 3) note_it(32'h3F, 32'h2A);
        end
        CARRIER_EN = 1'b0;
        note_it(32'h3F, 32'hE);
        $display("carrier test done");
        repeat (2) @(negedge CLOCK);
        close_out;
    end
    task close_out;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
endmodule // test_key_matrix_port_pins
bind key_matrix_port_pins key_matrix_port_pins_checker i_check (.*);
`default_nettype wire
